/* File: ffo_fifo_flags.sv */
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Output ready low after first word accepted
// - Almost-empty high at count n plus two
// - Half-full low at half depth plus two
// - Almost-full low after depth minus m writes
// - Input ready high when full, blocks writes
// - Output register counts as extra word
// - Reads from full release flags at thresholds
// - Almost-empty low at count n plus one
// - Output ready high after last read
// - Read enable ignored while empty
// - Output ready three stages, input ready two
// - Offset registers defaulted at master reset
// - Load select latched: serial or parallel
// - Offsets readable on data outputs
// - Offsets writable outside master reset, kept below depth
// - Synchronous almost flags on own clock
// - Asynchronous almost flags set/release split
// - Serial mode loads selected default offset
// - Eight default offsets from select pins
// - Parallel mode loads selected default offset
// - Fall-through mode latched at master reset
// - First word out after three read edges
module ffo_fifo_flags #(
  parameter int WIDTH = 18,
  parameter int MEM_DEPTH = 512
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic MASTER_RESET_N,
  input wire logic WRITE_CLK,
  input wire logic READ_CLK,
  input wire logic WRITE_EN_N,
  input wire logic READ_EN_N,
  input wire logic [WIDTH-1:0] DATA_IN,
  input wire logic OFFSET_LOAD_SELECT_N,
  input wire logic DEFAULT_OFFSET_SELECT0,
  input wire logic DEFAULT_OFFSET_SELECT1,
  input wire logic FLAG_TIMING_SELECT,
  input wire logic FALL_THROUGH_SELECT,
  output logic [WIDTH-1:0] DATA_OUTPUTS,
  output logic INPUT_READY_N,
  output logic OUTPUT_READY_N,
  output logic HALF_FULL_N,
  output logic ALMOST_FULL_N,
  output logic ALMOST_EMPTY_N,
  input wire logic [ffo_pkg::FFO_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  import ffo_pkg::*;

  localparam int DEPTH = MEM_DEPTH + 1;
  localparam int CNT_W = $clog2(DEPTH + FFO_PAE_ADD + 1);
  localparam int PTR_W = $clog2(MEM_DEPTH);
  localparam int PIN_W = 10;
  // Positions in the synchronised pin vector
  localparam int P_MRS = 9;
  localparam int P_WCLK = 8;
  localparam int P_RCLK = 7;
  localparam int P_WEN = 6;
  localparam int P_REN = 5;
  localparam int P_LDSEL = 4;
  localparam int P_TIMING = 1;
  localparam int P_FTS = 0;
  // Master reset and both enables start idle, so releasing RST_B
  // cannot look like a master reset with all straps low
  localparam logic [PIN_W-1:0] PIN_IDLE = 10'h260;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] MEM_C = CNT_W'(MEM_DEPTH);
  localparam logic [CNT_W-1:0] HALF_C = CNT_W'(MEM_DEPTH / 2 + FFO_HF_ADD);
  localparam logic [FFO_OFF_W-1:0] OFF_MAX = FFO_OFF_W'(DEPTH - 1);

  // Two-flop synchronisers for every pin
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [WIDTH-1:0] din_s1;
  logic [WIDTH-1:0] din_s2;
  logic wclk_d;
  logic rclk_d;
  wire logic [PIN_W-1:0] pin_raw = {MASTER_RESET_N, WRITE_CLK, READ_CLK,
    WRITE_EN_N, READ_EN_N, OFFSET_LOAD_SELECT_N, DEFAULT_OFFSET_SELECT0,
    DEFAULT_OFFSET_SELECT1, FLAG_TIMING_SELECT, FALL_THROUGH_SELECT};

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      din_s1 <= '0;
      din_s2 <= '0;
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      din_s1 <= DATA_IN;
      din_s2 <= din_s1;
      wclk_d <= pin_s2[P_WCLK];
      rclk_d <= pin_s2[P_RCLK];
    end
  end

  wire logic mrs_n = pin_s2[P_MRS];
  wire logic wen_n = pin_s2[P_WEN];
  wire logic ren_n = pin_s2[P_REN];
  wire logic [2:0] def_idx = pin_s2[P_LDSEL -: 3];
  wire logic strap_fts = pin_s2[P_FTS];
  wire logic strap_serial = pin_s2[P_LDSEL];
  wire logic strap_sync = pin_s2[P_TIMING];
  // A pin level shorter than one sample period may lose its edge
  wire logic w_edge = pin_s2[P_WCLK] & ~wclk_d;
  wire logic r_edge = pin_s2[P_RCLK] & ~rclk_d;

  // Configuration caught while master reset is held
  // Straps follow the pins until release; the last sample wins
  logic first_word_fall_through_mode;
  logic serial_mode;
  logic sync_timing;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      first_word_fall_through_mode <= 1'b1;
      serial_mode <= 1'b0;
      sync_timing <= 1'b1;
    end else if (!mrs_n) begin
      first_word_fall_through_mode <= strap_fts;
      serial_mode <= strap_serial;
      sync_timing <= strap_sync;
    end
  end

  // Storage
  // Memory has no reset: a word is never read before it is written
  logic [WIDTH-1:0] mem [MEM_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] mem_cnt;
  logic [WIDTH-1:0] out_word;
  logic out_valid;
  logic [FFO_FT_STAGES-1:0] ne_pipe;

  // Memory full is the only refusal; the output register adds one word
  wire logic wr_acc = w_edge & ~wen_n & (mem_cnt < MEM_C);
  wire logic rd_take = r_edge & ~ren_n & out_valid;
  wire logic ft_ready = ne_pipe[FFO_FT_STAGES-1] & (mem_cnt != '0);
  wire logic slot_free = ~out_valid | rd_take;
  wire logic want_load = first_word_fall_through_mode | ~ren_n;
  wire logic load_out = r_edge & ft_ready & slot_free & want_load;
  wire logic [CNT_W-1:0] next_mem_cnt = mem_cnt + CNT_W'(wr_acc)
    - CNT_W'(load_out);
  wire logic next_out_valid = load_out | (out_valid & ~rd_take);
  wire logic [PTR_W-1:0] wr_ptr_inc = (wr_ptr == PTR_W'(MEM_DEPTH - 1)) ?
    '0 : wr_ptr + PTR_W'(1);
  wire logic [PTR_W-1:0] rd_ptr_inc = (rd_ptr == PTR_W'(MEM_DEPTH - 1)) ?
    '0 : rd_ptr + PTR_W'(1);

  always_ff @(posedge CORE_CLK) begin
    if (wr_acc) begin
      mem[wr_ptr] <= din_s2;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      mem_cnt <= '0;
      out_valid <= 1'b0;
      out_word <= '0;
      ne_pipe <= '0;
    end else if (!mrs_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      mem_cnt <= '0;
      out_valid <= 1'b0;
      out_word <= '0;
      ne_pipe <= '0;
    end else begin
      mem_cnt <= next_mem_cnt;
      out_valid <= next_out_valid;
      if (wr_acc) begin
        wr_ptr <= wr_ptr_inc;
      end
      // Two read edges to see the word, the third moves it out
      if (r_edge) begin
        ne_pipe <= {ne_pipe[FFO_FT_STAGES-2:0], mem_cnt != '0};
      end
      if (load_out) begin
        out_word <= mem[rd_ptr];
        rd_ptr <= rd_ptr_inc;
      end
    end
  end

  // Flag thresholds on the count including the output register
  logic [FFO_OFF_W-1:0] empty_off;
  logic [FFO_OFF_W-1:0] full_off;
  wire logic [CNT_W-1:0] total = mem_cnt + CNT_W'(out_valid);
  wire logic [CNT_W-1:0] pae_lvl = CNT_W'(empty_off) + CNT_W'(FFO_PAE_ADD);
  wire logic [CNT_W-1:0] paf_lvl = DEPTH_C - CNT_W'(full_off);
  wire logic pae_above = total >= pae_lvl;
  wire logic paf_reach = total >= paf_lvl;
  wire logic hf_reach = total >= HALF_C;
  wire logic is_full = total == DEPTH_C;

  // Half-full and asynchronous almost flags follow the count one cycle after the edge that moved it; synchronous ones wait for their own clock
  logic w_upd;
  logic r_upd;
  logic ir_stage;
  logic or_stage;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      w_upd <= 1'b0;
      r_upd <= 1'b0;
      ir_stage <= 1'b0;
      or_stage <= 1'b1;
      INPUT_READY_N <= 1'b0;
      OUTPUT_READY_N <= 1'b1;
      HALF_FULL_N <= 1'b1;
      ALMOST_FULL_N <= 1'b1;
      ALMOST_EMPTY_N <= 1'b0;
    end else if (!mrs_n) begin
      w_upd <= 1'b0;
      r_upd <= 1'b0;
      ir_stage <= 1'b0;
      or_stage <= 1'b1;
      INPUT_READY_N <= 1'b0;
      OUTPUT_READY_N <= 1'b1;
      HALF_FULL_N <= 1'b1;
      ALMOST_FULL_N <= 1'b1;
      ALMOST_EMPTY_N <= 1'b0;
    end else begin
      w_upd <= w_edge;
      r_upd <= r_edge;
      // Input ready: two write-clock stages
      // Lags a full count by one write edge; refusal is immediate
      if (w_upd) begin
        ir_stage <= is_full;
        INPUT_READY_N <= ir_stage;
      end
      // Output ready: third stage behind the fall-through pipe
      // Moves only on read edges, so the read clock must keep running
      or_stage <= ~out_valid;
      if (r_upd) begin
        OUTPUT_READY_N <= or_stage;
      end
      if (w_upd | r_upd) begin
        HALF_FULL_N <= ~hf_reach;
      end
      if (sync_timing) begin
        if (w_upd) begin
          ALMOST_FULL_N <= ~paf_reach;
        end
        if (r_upd) begin
          ALMOST_EMPTY_N <= pae_above;
        end
      end else begin
        // Set and release come from opposite clocks
        if (w_upd & paf_reach) begin
          ALMOST_FULL_N <= 1'b0;
        end else if (r_upd & ~paf_reach) begin
          ALMOST_FULL_N <= 1'b1;
        end
        if (r_upd & ~pae_above) begin
          ALMOST_EMPTY_N <= 1'b0;
        end else if (w_upd & pae_above) begin
          ALMOST_EMPTY_N <= 1'b1;
        end
      end
    end
  end

  // Avalon slave: one wait cycle, answer at the following edge
  // Writes land, and read data stand, at the edge seeing waitrequest low
  logic bus_ack;
  logic [1:0] rb_sel;
  wire logic bus_req = AVS_READ | AVS_WRITE;
  wire logic [3:0] bus_ofs = {AVS_ADDRESS[3:2], 2'b00};
  wire logic bus_wr = AVS_WRITE & bus_ack;
  wire logic wr_empty = bus_wr & (bus_ofs == FFO_EMPTY_OFS);
  wire logic wr_full = bus_wr & (bus_ofs == FFO_FULL_OFS);
  wire logic wr_rb = bus_wr & (bus_ofs == FFO_READBACK_OFS);

  function automatic logic [FFO_OFF_W-1:0] merge_off(
    input logic [FFO_OFF_W-1:0] cur,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [15:0] old16;
    logic [15:0] new16;
    old16 = 16'(cur);
    // Only byte lanes 0 and 1 carry offset bits
    new16 = {be[1] ? wd[15:8] : old16[15:8], be[0] ? wd[7:0] : old16[7:0]};
    // Values past the last word are pulled back to depth minus one
    if (new16 > 16'(OFF_MAX)) begin
      new16 = 16'(OFF_MAX);
    end
    return new16[FFO_OFF_W-1:0];
  endfunction

  wire logic [FFO_OFF_W-1:0] empty_wr = merge_off(empty_off, AVS_WRITEDATA,
    AVS_BYTEENABLE);
  wire logic [FFO_OFF_W-1:0] full_wr = merge_off(full_off, AVS_WRITEDATA,
    AVS_BYTEENABLE);
  wire logic [FFO_OFF_W-1:0] def_off = ffo_default(def_idx);

  wire logic [31:0] status_word = {7'h00, ~OUTPUT_READY_N, ~ALMOST_EMPTY_N,
    ~HALF_FULL_N, ~ALMOST_FULL_N, ~INPUT_READY_N, 1'b0, sync_timing,
    serial_mode, first_word_fall_through_mode, 16'(total)};
  wire logic [31:0] rd_mux =
    (bus_ofs == FFO_STATUS_OFS) ? status_word :
    (bus_ofs == FFO_EMPTY_OFS) ? 32'(empty_off) :
    (bus_ofs == FFO_FULL_OFS) ? 32'(full_off) :
    32'(rb_sel);

  assign AVS_WAITREQUEST = bus_req & ~bus_ack;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bus_ack <= 1'b0;
      AVS_READDATA <= '0;
      empty_off <= FFO_OFF_RST;
      full_off <= FFO_OFF_RST;
      rb_sel <= FFO_RB_RST;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (AVS_READ & ~bus_ack) begin
        AVS_READDATA <= rd_mux;
      end
      // Either loading mode starts from the selected default
      if (!mrs_n) begin
        empty_off <= def_off;
        full_off <= def_off;
      end else begin
        if (wr_empty) begin
          empty_off <= empty_wr;
        end
        if (wr_full) begin
          full_off <= full_wr;
        end
      end
      if (wr_rb) begin
        rb_sel <= AVS_WRITEDATA[1:0];
      end
    end
  end

  // Data outputs: FIFO word or an offset for readback
  // Readback borrows the outputs; select 0 gives the FIFO word back
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DATA_OUTPUTS <= '0;
    end else if (rb_sel == FFO_RB_EMPTY) begin
      DATA_OUTPUTS <= WIDTH'(empty_off);
    end else if (rb_sel == FFO_RB_FULL) begin
      DATA_OUTPUTS <= WIDTH'(full_off);
    end else begin
      DATA_OUTPUTS <= out_word;
    end
  end
endmodule
`default_nettype wire

/* File: ffo_pkg.sv */
`default_nettype none
package ffo_pkg;
  localparam int FFO_ADDR_W = 4;
  localparam int FFO_OFF_W = 10;
  // Register byte offsets
  localparam logic [3:0] FFO_STATUS_OFS = 4'h0;
  localparam logic [3:0] FFO_EMPTY_OFS = 4'h4;
  localparam logic [3:0] FFO_FULL_OFS = 4'h8;
  localparam logic [3:0] FFO_READBACK_OFS = 4'hC;
  // Status field positions
  localparam int FFO_ST_FIRST_WORD_FALL_THROUGH = 16;
  localparam int FFO_ST_SERIAL = 17;
  localparam int FFO_ST_SYNC = 18;
  localparam int FFO_ST_IR = 20;
  localparam int FFO_ST_PAF = 21;
  localparam int FFO_ST_HF = 22;
  localparam int FFO_ST_PAE = 23;
  localparam int FFO_ST_OR = 24;
  // Readback select codes
  localparam logic [1:0] FFO_RB_DATA = 2'h0;
  localparam logic [1:0] FFO_RB_EMPTY = 2'h1;
  localparam logic [1:0] FFO_RB_FULL = 2'h2;
  // Reset values
  localparam logic [FFO_OFF_W-1:0] FFO_OFF_RST = 10'h07F;
  localparam logic [1:0] FFO_RB_RST = 2'h0;
  // Threshold distances from the offsets and the half mark; fall-through pipe stages
  localparam int FFO_PAE_ADD = 2;
  localparam int FFO_HF_ADD = 2;
  localparam int FFO_FT_STAGES = 2;

  // Index is {load select, select0, select1}
  function automatic logic [FFO_OFF_W-1:0] ffo_default(input logic [2:0] idx);
    logic [FFO_OFF_W-1:0] v;
    v = 10'h07F;
    case (idx)
      3'h0: v = 10'h07F;
      3'h1: v = 10'h1FF;
      3'h2: v = 10'h0FF;
      3'h3: v = 10'h03F;
      3'h4: v = 10'h01F;
      3'h5: v = 10'h00F;
      3'h6: v = 10'h007;
      3'h7: v = 10'h003;
      default: v = 10'h07F;
    endcase
    return v;
  endfunction
endpackage
`default_nettype wire

/* File: ffo_fifo_flags_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module ffo_fifo_flags_assertions (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic MASTER_RESET_N,
  input wire logic WRITE_CLK,
  input wire logic READ_CLK,
  input wire logic FLAG_TIMING_SELECT,
  input wire logic INPUT_READY_N,
  input wire logic OUTPUT_READY_N,
  input wire logic HALF_FULL_N,
  input wire logic ALMOST_FULL_N,
  input wire logic ALMOST_EMPTY_N
);
  logic [3:0] mr_sh;
  logic live;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) mr_sh <= 4'h0;
    else mr_sh <= {mr_sh[2:0], MASTER_RESET_N};
  end
  // Flags are forced while master reset ripples through its sync
  assign live = (&mr_sh) & MASTER_RESET_N;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  a_full_flags: assert property (INPUT_READY_N |->
    !ALMOST_FULL_N && !HALF_FULL_N && !OUTPUT_READY_N)
    else $error("full without matching flags");
  a_empty_flags: assert property (OUTPUT_READY_N |->
    HALF_FULL_N && !INPUT_READY_N) else $error("empty flag mismatch");
  a_or_rclk: assert property (live && $changed(OUTPUT_READY_N) |->
    READ_CLK) else $error("output ready moved off read clock");
  a_ir_wclk: assert property (live && $changed(INPUT_READY_N) |->
    WRITE_CLK) else $error("input ready moved off write clock");
  a_paf_sync: assert property (live && FLAG_TIMING_SELECT &&
    $changed(ALMOST_FULL_N) |-> WRITE_CLK)
    else $error("sync almost full moved off write clock");
  a_pae_sync: assert property (live && FLAG_TIMING_SELECT &&
    $changed(ALMOST_EMPTY_N) |-> READ_CLK)
    else $error("sync almost empty moved off read clock");
  a_paf_async: assert property (live && !FLAG_TIMING_SELECT &&
    $changed(ALMOST_FULL_N) |-> ($fell(ALMOST_FULL_N) ? WRITE_CLK : READ_CLK))
    else $error("async almost full on wrong clock");
  a_pae_async: assert property (live && !FLAG_TIMING_SELECT &&
    $changed(ALMOST_EMPTY_N) |->
    ($fell(ALMOST_EMPTY_N) ? READ_CLK : WRITE_CLK))
    else $error("async almost empty on wrong clock");
endmodule
bind ffo_fifo_flags ffo_fifo_flags_assertions ffo_fifo_flags_assertions_i (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .MASTER_RESET_N(MASTER_RESET_N),
  .WRITE_CLK(WRITE_CLK), .READ_CLK(READ_CLK),
  .FLAG_TIMING_SELECT(FLAG_TIMING_SELECT), .INPUT_READY_N(INPUT_READY_N),
  .OUTPUT_READY_N(OUTPUT_READY_N), .HALF_FULL_N(HALF_FULL_N),
  .ALMOST_FULL_N(ALMOST_FULL_N), .ALMOST_EMPTY_N(ALMOST_EMPTY_N));
`default_nettype wire

/* File: ffo_link_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ffo_link_model #(
  parameter int WIDTH = 18
) (
  output logic write_clk,
  output logic read_clk,
  output logic write_en_n,
  output logic read_en_n,
  output logic [WIDTH-1:0] data_in
);
  initial begin
    write_clk = 1'b0;
    write_en_n = 1'b1;
    read_en_n = 1'b1;
    data_in = '0;
    forever #62.5 write_clk = ~write_clk;
  end
  // Skew keeps the two clock domains at a fixed 37 ns phase offset
  initial begin
    read_clk = 1'b0;
    #37;
    forever #62.5 read_clk = ~read_clk;
  end
  task automatic put(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      @(negedge write_clk);
      write_en_n <= 1'b0;
      data_in <= WIDTH'(base + i);
    end
    @(negedge write_clk);
    write_en_n <= 1'b1;
    // Released bus must not keep showing the last word
    data_in <= ~data_in;
  endtask
  task automatic take(input int n);
    repeat (n) begin
      @(negedge read_clk);
      read_en_n <= 1'b0;
    end
    @(negedge read_clk);
    read_en_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ffo_pkg::*;
  localparam logic [9:0] DEF [8] = '{10'h07F, 10'h1FF, 10'h0FF, 10'h03F,
    10'h01F, 10'h00F, 10'h007, 10'h003};
  localparam int DEPTH = 513;
  logic clk, rst_b, mr_n, ls_n, sel0, sel1, timing, fts, rd_s, wr_s;
  logic wclk, rclk, wen_n, ren_n, ir_n, or_n, hf_n, paf_n, pae_n, wreq;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, rd;
  logic [17:0] din, dout;
  int num_errors = 0;
  int comparisons = 0;
  ffo_fifo_flags ffo_fifo_flags_i (.CORE_CLK(clk), .RST_B(rst_b),
    .MASTER_RESET_N(mr_n), .WRITE_CLK(wclk), .READ_CLK(rclk),
    .WRITE_EN_N(wen_n), .READ_EN_N(ren_n), .DATA_IN(din),
    .OFFSET_LOAD_SELECT_N(ls_n), .DEFAULT_OFFSET_SELECT0(sel0),
    .DEFAULT_OFFSET_SELECT1(sel1), .FLAG_TIMING_SELECT(timing),
    .FALL_THROUGH_SELECT(fts), .DATA_OUTPUTS(dout), .INPUT_READY_N(ir_n),
    .OUTPUT_READY_N(or_n), .HALF_FULL_N(hf_n), .ALMOST_FULL_N(paf_n),
    .ALMOST_EMPTY_N(pae_n), .AVS_ADDRESS(addr), .AVS_READ(rd_s),
    .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq));
  ffo_link_model ffo_link_model_i (.write_clk(wclk), .read_clk(rclk),
    .write_en_n(wen_n), .read_en_n(ren_n), .data_in(din));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    wr_s <= w;
    rd_s <= !w;
    addr <= a;
    wdata <= d;
    // Waitrequest and read data are judged at the same rising edge
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    q = rdata;
    if (k >= 20) check("bus answer", 32'h0, 32'h1);
    if (k >= 20) test_done();
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  task automatic mreset(input logic [2:0] idx, input logic sy, fw);
    @(posedge clk);
    {ls_n, sel0, sel1} <= idx;
    timing <= sy;
    fts <= fw;
    mr_n <= 1'b0;
    repeat (6) @(posedge clk);
    mr_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_defaults;
    for (int i = 0; i < 8; i++) begin
      mreset(i[2:0], i[0], i[1]);
      xfer(1'b0, FFO_EMPTY_OFS, 32'h0, rd);
      check("empty offset", {22'h0, DEF[i]}, rd);
      xfer(1'b0, FFO_FULL_OFS, 32'h0, rd);
      check("full offset", {22'h0, DEF[i]}, rd);
      xfer(1'b0, FFO_STATUS_OFS, 32'h0, rd);
      check("modes", {29'h0, i[0], i[2], i[1]},
        {29'h0, rd[18:16]});
    end
  endtask
  task automatic t_readback;
    // Readback must work in both load modes
    for (int ld = 0; ld < 2; ld++) begin
      mreset({ld[0], 2'b00}, 1'b1, 1'b1);
      xfer(1'b1, FFO_EMPTY_OFS, 32'h5, rd);
      xfer(1'b1, FFO_FULL_OFS, 32'hA, rd);
      for (int s = 1; s < 3; s++) begin
        xfer(1'b1, FFO_READBACK_OFS, 32'(s), rd);
        repeat (3) @(posedge clk);
        check("readback", (s == 1) ? 32'h5 : 32'hA, 32'(dout));
      end
      xfer(1'b1, FFO_READBACK_OFS, 32'h0, rd);
    end
  endtask
  task automatic settle(input int c, input int hd);
    logic [4:0] e;
    int k;
    e = {c == DEPTH, c < DEPTH - 10, c < 258, c >= 7, c == 0};
    k = 0;
    while ({ir_n, paf_n, hf_n, pae_n, or_n} !== e && k < 200) begin
      @(negedge clk);
      k++;
    end
    check("flags", 32'(e), 32'({ir_n, paf_n, hf_n, pae_n, or_n}));
    if (k >= 200) test_done();
    xfer(1'b0, FFO_STATUS_OFS, 32'h0, rd);
    check("count", c, 32'(rd[9:0]));
    if (c > 0) check("head word", hd, 32'(dout));
  endtask
  task automatic t_fill_drain(input logic sy);
    int seq [19] = '{1, 6, 7, 257, 258, 502, 503, 513, 514, 512, 503, 502,
      258, 257, 7, 6, 1, 0, -1};
    int c, r;
    c = 0;
    r = 0;
    mreset(3'h0, sy, 1'b1);
    // Empty offset 5, full offset 10
    xfer(1'b1, FFO_EMPTY_OFS, 32'h5, rd);
    xfer(1'b1, FFO_FULL_OFS, 32'hA, rd);
    foreach (seq[j]) begin
      if (seq[j] > c) ffo_link_model_i.put(seq[j] - c, c);
      else if (seq[j] < 0) ffo_link_model_i.take(1);
      else ffo_link_model_i.take(c - seq[j]);
      if (seq[j] >= 0 && seq[j] <= c) r = r + c - seq[j];
      if (seq[j] >= 0) c = (seq[j] > DEPTH) ? DEPTH : seq[j];
      settle(c, r);
    end
  endtask
  initial begin
    rst_b = 1'b0;
    mr_n = 1'b1;
    {ls_n, sel0, sel1} = 3'h0;
    timing = 1'b1;
    fts = 1'b1;
    rd_s = 1'b0;
    wr_s = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_defaults();
    t_readback();
    t_fill_drain(1'b1);
    t_fill_drain(1'b0);
    test_done();
  end
endmodule
`default_nettype wire
